// ===== design/accel_sys_pkg.sv
// shared constants, types and lookup tables for the system control block
package accel_sys_pkg;

  localparam logic [7:0] ADDR_POWER_RESET_CONTROL = 8'h2b;
  localparam logic [7:0] ADDR_WAKE_SOURCE_CONTROL = 8'h2c;
  localparam logic [7:0] POWER_RESET_CONTROL_RESET = 8'h00;
  localparam logic [7:0] WAKE_SOURCE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // serial port slave address: value is arbitrary
  localparam logic [6:0] DEVICE_ADDRESS = 7'h3a;

  // power_reset_control field positions
  localparam int BIT_SELF_TEST = 7;
  localparam int BIT_SOFT_RESET = 6;
  localparam int SLEEP_SCHEME_LSB = 3;
  localparam int BIT_AUTO_SLEEP = 2;
  localparam int WAKE_SCHEME_LSB = 0;

  // wake_source_control field positions
  localparam int BIT_FIFO_GATE = 7;
  localparam int WAKE_ENABLE_LSB = 3;
  localparam int BIT_IRQ_POLARITY = 1;
  localparam int BIT_IRQ_DRIVE_TYPE = 0;
  localparam int WAKE_SOURCES = 4;

  // boot time after a software reset
  localparam int CLK_PERIOD_NS = 40;
  localparam int BOOT_TIME_NS = 1000;
  localparam logic [5:0] BOOT_CYCLES =
    6'((BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    SCHEME_NORMAL,
    SCHEME_LOW_NOISE,
    SCHEME_HIGH_RES,
    SCHEME_LOW_POWER
  } power_scheme_t;

  typedef struct packed {
    logic self_test_enable;
    power_scheme_t sleep_power_scheme;
    logic auto_sleep_enable;
    power_scheme_t wake_power_scheme;
  } power_reset_t;

  // wake enables ordered transient, orientation, pulse, freefall/motion
  typedef struct packed {
    logic fifo_gate;
    logic [WAKE_SOURCES-1:0] wake_enable;
    logic irq_polarity;
    logic irq_drive_type;
  } wake_source_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // log2 of the oversampling ratio, [scheme][rate code]
  // rate code 0..7 = 800, 400, 200, 100, 50, 12.5, 6.25, 1.56 Hz
  localparam logic [3:0] OS_LOG2 [4][8] = '{
    '{4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h4, 4'h5, 4'h7},
    '{4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h5},
    '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'ha},
    '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h4}
  };

endpackage : accel_sys_pkg

// ===== design/serial_register_port.sv
// two-wire serial slave that turns bus frames into register accesses
`timescale 1ns/1ps
module serial_register_port (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [7:0] i_rdata,
  output logic o_sda_out,
  output logic o_sda_oe,
  output accel_sys_pkg::reg_req_t o_req
);
  typedef enum {
    IDLE, ADDR, ADDR_ACK, REG_PTR, PTR_ACK, WDATA, WDATA_ACK, RDATA,
    RDATA_ACK
  } port_state_t;

  port_state_t state;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  logic [2:0] cnt;
  logic full;
  logic rw;
  logic nack;
  logic [7:0] shift;
  logic [7:0] ptr;
  logic wr;
  logic [7:0] wdata;
  logic next_oe;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // pins pass two flops before anything looks at them
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (i_ce) begin
      scl_sync <= {scl_sync[0], i_scl};
      sda_sync <= {sda_sync[0], i_sda};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
    end
  end

  assign scl_rise = scl_sync[1] & ~scl_q;
  assign scl_fall = ~scl_sync[1] & scl_q;
  assign start_cond = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  assign stop_cond = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

  // bits are sampled on clock rise, the slave changes sda after the fall
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= IDLE;
      cnt <= 3'h0;
      full <= 1'b0;
      rw <= 1'b0;
      nack <= 1'b0;
      shift <= 8'h00;
      ptr <= 8'h00;
      wr <= 1'b0;
      wdata <= 8'h00;
    end else if (i_ce) begin
      wr <= 1'b0;
      if (start_cond) begin
        state <= ADDR;
        cnt <= 3'h0;
        full <= 1'b0;
      end else if (stop_cond) begin
        state <= IDLE;
      end else if (scl_rise) begin
        if (state inside {ADDR, REG_PTR, WDATA}) begin
          shift <= {shift[6:0], sda_sync[1]};
          cnt <= cnt + 3'h1;
          full <= (cnt == 3'h7);
        end else if (state == RDATA) begin
          cnt <= cnt + 3'h1;
          full <= (cnt == 3'h7);
        end else if (state == RDATA_ACK) begin
          nack <= sda_sync[1];
          if (!sda_sync[1]) begin
            ptr <= ptr + 8'h01;
          end
        end
      end else if (scl_fall) begin
        unique case (state)
          IDLE: ;
          ADDR: if (full) begin
            full <= 1'b0;
            rw <= shift[0];
            state <= (shift[7:1] == accel_sys_pkg::DEVICE_ADDRESS) ?
                     ADDR_ACK : IDLE;
          end
          ADDR_ACK: if (rw) begin
            shift <= i_rdata;
            state <= RDATA;
          end else begin
            state <= REG_PTR;
          end
          REG_PTR: if (full) begin
            full <= 1'b0;
            ptr <= shift;
            state <= PTR_ACK;
          end
          PTR_ACK: state <= WDATA;
          WDATA: if (full) begin
            full <= 1'b0;
            wr <= 1'b1;
            wdata <= shift;
            state <= WDATA_ACK;
          end
          WDATA_ACK: begin
            ptr <= ptr + 8'h01;
            state <= WDATA;
          end
          RDATA: if (full) begin
            full <= 1'b0;
            state <= RDATA_ACK;
          end else begin
            shift <= {shift[6:0], 1'b0};
          end
          RDATA_ACK: if (nack) begin
            state <= IDLE;
          end else begin
            shift <= i_rdata;
            state <= RDATA;
          end
        endcase
      end
    end
  end

  assign next_oe = (state inside {ADDR_ACK, PTR_ACK, WDATA_ACK}) ||
                   (state == RDATA && !shift[7]);

  // open drain: only ever pulls low
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_sda_oe <= 1'b0;
    end else if (i_ce) begin
      o_sda_oe <= next_oe;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_req = '{wr: wr, addr: ptr, wdata: wdata};

endmodule : serial_register_port

// ===== design/system_power_scheme_control.sv
// power scheme, software reset and wake source control registers
//
// Overview of operation
// - the self-test bit of power_reset_control drives the axis shift.
// - writing one to the software reset bit resets at once, any mode.
// - a software reset puts every register back to its default.
// - a software reset also resets the serial port logic.
// - the software reset bit clears at end of boot and reads zero.
// - the auto-sleep bit allows wake to sleep moves when set.
// - bits 1-0 pick the oversampling scheme while awake, default 00.
// - bits 4-3 pick the oversampling scheme while asleep, default 00.
// - schemes: 00 normal, 01 low noise, 10 high res, 11 low power.
// - normal and high res ratios follow the per-rate table.
// - low noise and low power ratios follow the per-rate table.
// - wake_source_control holds gate and four wake enables, bit 2 zero.
// - bits 1 and 0 set interrupt pin polarity and drive type.
// - a set wake enable lets its function's event end sleep.
// - with the gate clear, the fifo is flushed on wake/sleep moves.
// - with the gate set, the fifo is held; a sample offered while held flags a gate error.
`timescale 1ns/1ps
module system_power_scheme_control (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_active,
  input wire logic [2:0] i_data_rate,
  input wire logic i_inactivity_timeout,
  input wire logic [3:0] i_wake_events,
  input wire logic i_sample_valid,
  input wire logic i_fifo_empty,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_self_test,
  output logic o_soft_reset,
  output logic o_sleep,
  output accel_sys_pkg::power_scheme_t o_power_scheme,
  output logic [10:0] o_os_ratio,
  output logic o_fifo_flush,
  output logic o_fifo_blocked,
  output logic o_sample_accept,
  output logic o_gate_error_flag,
  output logic o_irq_polarity,
  output logic o_irq_drive_type
);
  typedef enum {STANDBY, WAKE, SLEEP} mode_t;

  accel_sys_pkg::reg_req_t req;
  accel_sys_pkg::power_reset_t power_reset_control;
  accel_sys_pkg::wake_source_t wake_source_control;
  mode_t mode;
  mode_t next_mode;
  logic boot_busy;
  logic [5:0] boot_cnt;
  logic sys_rst;
  logic [7:0] rdata;
  logic [3:0] wake_req;
  logic mode_change;
  logic swrst_write;
  accel_sys_pkg::power_scheme_t next_scheme;

  // the port is held in reset through boot so no half frame gets through
  assign sys_rst = i_srst | boot_busy;

  serial_register_port port (
    .i_clk(i_clk),
    .i_srst(sys_rst),
    .i_ce(i_ce),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_rdata(rdata),
    .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe),
    .o_req(req)
  );

  assign swrst_write = req.wr &&
    req.addr == accel_sys_pkg::ADDR_POWER_RESET_CONTROL &&
    req.wdata[accel_sys_pkg::BIT_SOFT_RESET];

  // the reset bit lives only as the boot timer; it is never stored
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      boot_busy <= 1'b0;
      boot_cnt <= 6'h00;
    end else if (i_ce) begin
      if (boot_busy) begin
        if (boot_cnt == accel_sys_pkg::BOOT_CYCLES - 6'h01) begin
          boot_busy <= 1'b0;
        end else begin
          boot_cnt <= boot_cnt + 6'h01;
        end
      end else if (swrst_write) begin
        boot_busy <= 1'b1;
        boot_cnt <= 6'h00;
      end
    end
  end

  // a write that asks for reset stores nothing else: reset wins
  always_ff @(posedge i_clk) begin
    if (sys_rst) begin
      // the stored copy skips the reset bit and bit 5, so pick fields
      power_reset_control <= accel_sys_pkg::power_reset_t'({
        accel_sys_pkg::POWER_RESET_CONTROL_RESET[
          accel_sys_pkg::BIT_SELF_TEST],
        accel_sys_pkg::POWER_RESET_CONTROL_RESET[
          accel_sys_pkg::SLEEP_SCHEME_LSB+1:0]});
      wake_source_control <= accel_sys_pkg::wake_source_t'({
        accel_sys_pkg::WAKE_SOURCE_CONTROL_RESET[
          accel_sys_pkg::BIT_FIFO_GATE:accel_sys_pkg::WAKE_ENABLE_LSB],
        accel_sys_pkg::WAKE_SOURCE_CONTROL_RESET[
          accel_sys_pkg::BIT_IRQ_POLARITY:0]});
    end else if (i_ce && req.wr && !swrst_write) begin
      if (req.addr == accel_sys_pkg::ADDR_POWER_RESET_CONTROL) begin
        power_reset_control <= '{
          self_test_enable: req.wdata[accel_sys_pkg::BIT_SELF_TEST],
          sleep_power_scheme: accel_sys_pkg::power_scheme_t'(
            req.wdata[accel_sys_pkg::SLEEP_SCHEME_LSB +: 2]),
          auto_sleep_enable: req.wdata[accel_sys_pkg::BIT_AUTO_SLEEP],
          wake_power_scheme: accel_sys_pkg::power_scheme_t'(
            req.wdata[accel_sys_pkg::WAKE_SCHEME_LSB +: 2])
        };
      end
      if (req.addr == accel_sys_pkg::ADDR_WAKE_SOURCE_CONTROL) begin
        wake_source_control <= '{
          fifo_gate: req.wdata[accel_sys_pkg::BIT_FIFO_GATE],
          wake_enable: req.wdata[accel_sys_pkg::WAKE_ENABLE_LSB +:
                                 accel_sys_pkg::WAKE_SOURCES],
          irq_polarity: req.wdata[accel_sys_pkg::BIT_IRQ_POLARITY],
          irq_drive_type: req.wdata[accel_sys_pkg::BIT_IRQ_DRIVE_TYPE]
        };
      end
    end
  end

  // reset bit and bit 5 read back as zero, as does bit 2 of the second
  always_comb begin
    rdata = accel_sys_pkg::UNMAPPED_READ_VALUE;
    if (req.addr == accel_sys_pkg::ADDR_POWER_RESET_CONTROL) begin
      rdata = {power_reset_control.self_test_enable, 2'h0,
               power_reset_control.sleep_power_scheme,
               power_reset_control.auto_sleep_enable,
               power_reset_control.wake_power_scheme};
    end else if (req.addr == accel_sys_pkg::ADDR_WAKE_SOURCE_CONTROL) begin
      rdata = {wake_source_control.fifo_gate,
               wake_source_control.wake_enable, 1'b0,
               wake_source_control.irq_polarity,
               wake_source_control.irq_drive_type};
    end
  end

  genvar k;
  generate
    for (k = 0; k < accel_sys_pkg::WAKE_SOURCES; k++) begin : g_wake
      assign wake_req[k] = i_wake_events[k] &
                           wake_source_control.wake_enable[k];
    end
  endgenerate

  always_comb begin
    next_mode = mode;
    unique case (mode)
      STANDBY: if (i_active) next_mode = WAKE;
      WAKE: if (!i_active) begin
        next_mode = STANDBY;
      end else if (power_reset_control.auto_sleep_enable &&
                   i_inactivity_timeout) begin
        next_mode = SLEEP;
      end
      SLEEP: if (!i_active) begin
        next_mode = STANDBY;
      end else if (|wake_req ||
                   !power_reset_control.auto_sleep_enable) begin
        next_mode = WAKE;
      end
    endcase
  end

  assign mode_change = (mode == WAKE && next_mode == SLEEP) ||
                       (mode == SLEEP && next_mode == WAKE);

  always_ff @(posedge i_clk) begin
    if (sys_rst) begin
      mode <= STANDBY;
    end else if (i_ce) begin
      mode <= next_mode;
    end
  end

  // an empty fifo in the same cycle as a new block loses to the block
  always_ff @(posedge i_clk) begin
    if (sys_rst) begin
      o_fifo_flush <= 1'b0;
      o_fifo_blocked <= 1'b0;
      o_gate_error_flag <= 1'b0;
    end else if (i_ce) begin
      o_fifo_flush <= mode_change &&
                      !wake_source_control.fifo_gate;
      if (mode_change && wake_source_control.fifo_gate) begin
        o_fifo_blocked <= 1'b1;
      end else if (i_fifo_empty) begin
        o_fifo_blocked <= 1'b0;
      end
      if (o_fifo_blocked && i_sample_valid) begin
        o_gate_error_flag <= 1'b1;
      end else if (i_fifo_empty) begin
        o_gate_error_flag <= 1'b0;
      end
    end
  end

  assign o_sample_accept = i_sample_valid & ~o_fifo_blocked;

  assign next_scheme = (mode == SLEEP) ?
    power_reset_control.sleep_power_scheme :
    power_reset_control.wake_power_scheme;

  // ratio is a power of two, so the table keeps only its exponent
  always_ff @(posedge i_clk) begin
    if (sys_rst) begin
      o_power_scheme <= accel_sys_pkg::SCHEME_NORMAL;
      o_os_ratio <= 11'h000;
    end else if (i_ce) begin
      o_power_scheme <= next_scheme;
      o_os_ratio <= 11'h001 <<
        accel_sys_pkg::OS_LOG2[next_scheme][i_data_rate];
    end
  end

  assign o_self_test = power_reset_control.self_test_enable;
  assign o_irq_polarity = wake_source_control.irq_polarity;
  assign o_irq_drive_type = wake_source_control.irq_drive_type;
  assign o_soft_reset = boot_busy;
  assign o_sleep = (mode == SLEEP);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence seq_swrst_request;
    i_ce && swrst_write && !boot_busy;
  endsequence
  sequence seq_boot_hold;
    boot_busy [*8];
  endsequence

  AST_SWRST_IMMEDIATE: assert property (
    seq_swrst_request |=> seq_boot_hold)
    else $error("software reset did not start boot at once");

  AST_DEFAULTS_AFTER_RESET: assert property (
    boot_busy |=> (o_self_test == 1'b0 && o_irq_polarity == 1'b0 &&
                   o_irq_drive_type == 1'b0 && rdata[7:0] == 8'h00))
    else $error("register not at default after software reset");

  AST_PORT_RESET: assert property (
    seq_swrst_request ##1 boot_busy |=> (!o_sda_oe && !req.wr))
    else $error("serial port active during boot");

  AST_RESET_BIT_CLEARS: assert property (
    (boot_busy && i_ce &&
     boot_cnt == accel_sys_pkg::BOOT_CYCLES - 6'h01) |=> !o_soft_reset)
    else $error("reset bit did not clear at end of boot");

  AST_RESET_BIT_READS_ZERO: assert property (
    (req.addr == accel_sys_pkg::ADDR_POWER_RESET_CONTROL) |->
      (rdata[6] == 1'b0 && rdata[5] == 1'b0))
    else $error("reset bit or bit 5 reads nonzero");

  AST_SELF_TEST_WRITE: assert property (
    (i_ce && req.wr && !swrst_write && !boot_busy &&
     req.addr == accel_sys_pkg::ADDR_POWER_RESET_CONTROL) |=>
      (o_self_test == $past(req.wdata[7])))
    else $error("self test output does not follow the write");

  AST_AUTO_SLEEP_GATE: assert property (
    (mode == WAKE && !power_reset_control.auto_sleep_enable) |=>
      mode != SLEEP)
    else $error("entered sleep with auto-sleep disabled");

  AST_SLEEP_RATIO: assert property (
    (i_ce && !boot_busy && mode == SLEEP && i_data_rate == 3'h7 &&
     next_scheme == accel_sys_pkg::SCHEME_HIGH_RES) |=>
      o_os_ratio == 11'h400)
    else $error("high resolution ratio at lowest rate is wrong");

  AST_WAKE_ON_EVENT: assert property (
    (i_ce && !boot_busy && mode == SLEEP && i_active &&
     |(i_wake_events & wake_source_control.wake_enable)) |=>
      mode == WAKE)
    else $error("enabled wake source did not end sleep");

  AST_FLUSH_ON_MOVE: assert property (
    (i_ce && !boot_busy && mode_change &&
     !wake_source_control.fifo_gate) |=> o_fifo_flush ##1 !o_fifo_flush)
    else $error("fifo not flushed for one cycle on mode move");

  AST_GATE_ERROR: assert property (
    (i_ce && !boot_busy && o_fifo_blocked && i_sample_valid) |->
      (!o_sample_accept ##1 o_gate_error_flag))
    else $error("blocked sample accepted or gate error missing");

  AST_SLEEP_SCHEME: assert property (
    (i_ce && !boot_busy && mode == SLEEP) |=>
      o_power_scheme == $past(power_reset_control.sleep_power_scheme))
    else $error("sleep power scheme not applied while asleep");

  AST_NO_STRAY_FLUSH: assert property (
    (i_ce && !boot_busy && !mode_change) |=> !o_fifo_flush)
    else $error("fifo flushed without a mode move");

  AST_GATE_HOLDS_FIFO: assert property (
    (i_ce && !boot_busy && mode_change && wake_source_control.fifo_gate) |=>
      (o_fifo_blocked && !o_fifo_flush))
    else $error("gated fifo was flushed or not blocked on mode move");

  AST_IRQ_CONFIG_WRITE: assert property (
    (i_ce && req.wr && !boot_busy &&
     req.addr == accel_sys_pkg::ADDR_WAKE_SOURCE_CONTROL) |=>
      (o_irq_polarity == $past(req.wdata[accel_sys_pkg::BIT_IRQ_POLARITY]) &&
       o_irq_drive_type ==
         $past(req.wdata[accel_sys_pkg::BIT_IRQ_DRIVE_TYPE])))
    else $error("interrupt pin configuration does not follow the write");

endmodule : system_power_scheme_control

// ===== bench/serial_host_model.sv
// serial bus host that issues register frames to the block
`timescale 1ns/1ps
module serial_host_model (
  input wire logic i_clk,
  input wire logic i_sda_oe,
  output logic o_scl,
  output logic o_sda
);
  logic pull_low = 1'b0;
  logic [6:0] dev_addr = accel_sys_pkg::DEVICE_ADDRESS;
  initial o_scl = 1'b1;
  // pull-up: a released line reads high, never the last driven value
  assign o_sda = ~(pull_low | i_sda_oe);

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick

  // data moves mid low phase; 8-cycle phases beat the 6-cycle minimum
  task automatic clk_bit(input logic b, output logic got);
    tick(3);
    pull_low <= ~b;
    tick(5);
    o_scl <= 1'b1;
    tick(4);
    got = o_sda;
    tick(4);
    o_scl <= 1'b0;
  endtask : clk_bit

  // serves as first start and as repeated start
  task automatic start_cond();
    tick(3);
    pull_low <= 1'b0;
    tick(5);
    o_scl <= 1'b1;
    tick(8);
    pull_low <= 1'b1;
    tick(8);
    o_scl <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    tick(3);
    pull_low <= 1'b1;
    tick(5);
    o_scl <= 1'b1;
    tick(8);
    pull_low <= 1'b0;
    tick(8);
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) clk_bit(v[i], g);
    clk_bit(1'b1, g);
    ack = ~g;
  endtask : send_byte

  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] v,
                           output logic ack);
    logic a0, a1, a2;
    start_cond();
    send_byte({dev_addr, 1'b0}, a0);
    send_byte(ptr, a1);
    send_byte(v, a2);
    stop_cond();
    ack = a0 & a1 & a2;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] v);
    logic a;
    start_cond();
    send_byte({dev_addr, 1'b0}, a);
    send_byte(ptr, a);
    start_cond();
    send_byte({dev_addr, 1'b1}, a);
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, v[i]);
    // no acknowledge ends the read
    clk_bit(1'b1, a);
    stop_cond();
  endtask : read_reg
endmodule : serial_host_model

// ===== bench/tb.sv
// self-checking bench for the power scheme control block
`timescale 1ns/1ps
module tb;
  logic i_clk, i_srst, i_active, i_inactivity_timeout;
  logic i_sample_valid, i_fifo_empty, scl, sda;
  logic [2:0] i_data_rate;
  logic [3:0] i_wake_events;
  logic o_sda_oe, o_self_test, o_soft_reset, o_sleep, o_fifo_flush;
  logic o_fifo_blocked, o_sample_accept, o_gate_error_flag;
  logic o_irq_polarity, o_irq_drive_type, ack, sda_out, ce;
  accel_sys_pkg::power_scheme_t o_power_scheme;
  logic [10:0] o_os_ratio;
  logic [7:0] rd;
  int n_errors = 0, samples_checked = 0, flushes = 0, boot_len = 0;
  int f0, b0;
  // ratio per scheme, rate codes 800 Hz down to 1.56 Hz
  int os_tab [4][8] = '{'{2, 4, 4, 4, 4, 16, 32, 128},
    '{2, 4, 4, 4, 4, 4, 8, 32}, '{2, 4, 8, 16, 32, 128, 256, 1024},
    '{2, 2, 2, 2, 2, 2, 4, 16}};

  system_power_scheme_control dut (.i_clk, .i_srst, .i_ce(ce),
    .i_scl(scl), .i_sda(sda), .i_active, .i_data_rate,
    .i_inactivity_timeout, .i_wake_events, .i_sample_valid, .i_fifo_empty,
    .o_sda_out(sda_out), .o_sda_oe, .o_self_test, .o_soft_reset, .o_sleep,
    .o_power_scheme, .o_os_ratio, .o_fifo_flush, .o_fifo_blocked,
    .o_sample_accept, .o_gate_error_flag, .o_irq_polarity,
    .o_irq_drive_type);
  serial_host_model host (.i_clk, .i_sda_oe(o_sda_oe), .o_scl(scl),
    .o_sda(sda));

  // pulse and boot counters, so short pulses are never missed
  always @(posedge i_clk) begin
    if (o_fifo_flush === 1'b1) flushes <= flushes + 1;
    if (o_soft_reset === 1'b1) boot_len <= boot_len + 1;
  end

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.write_reg(a, v, ack);
    settle(2);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(a, rd);
    chk(11'(rd), 11'(exp));
  endtask : rchk

  task automatic strobe(input logic t, input logic [3:0] w);
    @(posedge i_clk);
    i_inactivity_timeout <= t;
    i_wake_events <= w;
    @(posedge i_clk);
    i_inactivity_timeout <= 1'b0;
    i_wake_events <= 4'h0;
    settle(3);
  endtask : strobe

  task automatic t_defaults();
    rchk(8'h2b, 8'h00);
    rchk(8'h2c, 8'h00);
    chk(11'(o_self_test), 11'h0);
    chk(o_os_ratio, 11'h2);
    chk(11'(sda_out), 11'h0);
  endtask : t_defaults

  task automatic t_fields();
    wr(8'h2b, 8'hbd);
    rchk(8'h2b, 8'h9d);
    chk(11'(o_self_test), 11'h1);
    wr(8'h2b, 8'h00);
    chk(11'(o_self_test), 11'h0);
    wr(8'h2c, 8'hff);
    rchk(8'h2c, 8'hfb);
    chk(11'({o_irq_polarity, o_irq_drive_type}), 11'h3);
    wr(8'h2c, 8'h02);
    chk(11'({o_irq_polarity, o_irq_drive_type}), 11'h2);
  endtask : t_fields

  task automatic t_schemes();
    @(posedge i_clk);
    i_active <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(8'h2b, 8'(s));
      for (int r = 0; r < 8; r++) begin
        @(posedge i_clk);
        i_data_rate <= 3'(r);
        settle(3);
        chk(11'(o_power_scheme), 11'(s));
        chk(o_os_ratio, 11'(os_tab[s][r]));
      end
    end
  endtask : t_schemes

  task automatic t_sleep();
    wr(8'h2b, 8'h10);
    strobe(1'b1, 4'h0);
    chk(11'(o_sleep), 11'h0);
    wr(8'h2c, 8'h40);
    wr(8'h2b, 8'h14);
    // a frozen block must ignore the sleep request
    @(posedge i_clk);
    ce <= 1'b0;
    strobe(1'b1, 4'h0);
    chk(11'(o_sleep), 11'h0);
    @(posedge i_clk);
    ce <= 1'b1;
    f0 = flushes;
    strobe(1'b1, 4'h0);
    chk(11'(o_sleep), 11'h1);
    chk(11'(o_power_scheme), 11'h2);
    chk(11'(flushes - f0), 11'h1);
    strobe(1'b0, 4'h7);
    chk(11'(o_sleep), 11'h1);
    strobe(1'b0, 4'h8);
    chk(11'(o_sleep), 11'h0);
    chk(11'(o_power_scheme), 11'h0);
    chk(11'(flushes - f0), 11'h2);
  endtask : t_sleep

  task automatic t_gate();
    wr(8'h2c, 8'hc0);
    f0 = flushes;
    strobe(1'b1, 4'h0);
    chk(11'(o_fifo_blocked), 11'h1);
    chk(11'(flushes - f0), 11'h0);
    @(posedge i_clk);
    i_sample_valid <= 1'b1;
    #1;
    chk(11'(o_sample_accept), 11'h0);
    @(posedge i_clk);
    i_sample_valid <= 1'b0;
    settle(1);
    chk(11'(o_gate_error_flag), 11'h1);
    @(posedge i_clk);
    i_fifo_empty <= 1'b1;
    settle(3);
    chk(11'({o_fifo_blocked, o_gate_error_flag}), 11'h0);
    @(posedge i_clk);
    i_fifo_empty <= 1'b0;
  endtask : t_gate

  // reset while asleep, with both registers holding nonzero values
  task automatic t_soft_reset();
    chk(11'(o_sleep), 11'h1);
    b0 = boot_len;
    host.write_reg(8'h2b, 8'h40, ack);
    settle(2);
    chk(11'(boot_len - b0), 11'(accel_sys_pkg::BOOT_CYCLES));
    chk(11'(o_sleep), 11'h0);
    rchk(8'h2b, 8'h00);
    rchk(8'h2c, 8'h00);
  endtask : t_soft_reset

  task automatic give_verdict();
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  initial begin
    i_srst = 1'b1;
    ce = 1'b1;
    i_active = 1'b0;
    i_data_rate = 3'h0;
    i_inactivity_timeout = 1'b0;
    i_wake_events = 4'h0;
    i_sample_valid = 1'b0;
    i_fifo_empty = 1'b0;
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    settle(4);
    t_defaults();
    t_fields();
    t_schemes();
    t_sleep();
    t_gate();
    t_soft_reset();
    give_verdict();
  end

  // whole run is near 10000 cycles; this cuts a hang
  initial begin
    repeat (60000) @(posedge i_clk);
    n_errors++;
    give_verdict();
  end
endmodule : tb
